// [core/pfcp_ctrl.sv]
// host controller that walks flash command sequences on the pins
// assumes a flash that follows the unlock command table; one clock
`timescale 1ns/1ps
`include "pfcp_regs.svh"

// Overview of operation
// RL1 - reads drive select and output enable low, write strobe high, then sample
// RL2 - host releases data pins whenever output enable is low
// RL3 - after reset, pins idle deselected so the device sits in standby
// RL4 - command writes pulse write strobe low with select low, output enable high
// RL5 - address stable before strobe falls, data stable until after it rises
// RL6 - command writes never stand in for array data updates
// RL7 - erase a block before reprogramming; erased bits read as one
// RL8 - chip erase is a six-write sequence of fixed address and data
// RL9 - chip erase is waited out by polling, bounded by the erase time
// RL10 - chip erase clears all blocks, boot block only if unlocked
// RL11 - no new command is issued while an erase is running
// RL12 - sector erase sixth write carries sector address with code 30
// RL13 - after sector erase sixth write, poll until the device finishes
// RL14 - each parameter and main block erased and programmed independently
// RL15 - programming only clears bits; mismatch after program is an error
// RL16 - byte program is four writes, then device times itself
// RL17 - program completion is bounded by the byte program time
// RL18 - after lock sequence, refuse program or erase of the boot block
// RL19 - wait for the end of a program cycle before any new access
// RL20 - 19-bit address and 8-bit data on the pins
// RL21 - every command opens with AA to 555 and 55 to AAA; the reset op here is a single F0 write with no unlock
// RL22 - bit 7 reads complemented while programming, true when done
// RL23 - bit 6 toggles while busy; two equal reads mean done
// RL24 - boot block spans offsets 00000 through 03FFF
// RL25 - sequences are always written whole, never broken part way
module pfcp_ctrl
#(
  parameter int unsigned ERASE_CYCLES = `PFCP_EC_CYC
)
(
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       arst_n_in,
  // command port
  input  wire logic                       cmd_valid_in,
  input  wire pfcp_pkg::pfcp_op_t         cmd_op_in,
  input  wire logic [`PFCP_ADDR_W-1:0]    cmd_addr_in,
  input  wire logic [`PFCP_DATA_W-1:0]    cmd_data_in,
  output logic                            cmd_ready_out,
  // response
  output logic                            rsp_valid_out,
  output logic [`PFCP_DATA_W-1:0]         rsp_data_out,
  output logic                            rsp_err_out,
  output logic                            boot_locked_out,
  // flash pins
  input  wire logic [`PFCP_DATA_W-1:0]    flash_data_in,
  output logic [`PFCP_ADDR_W-1:0]         flash_addr_out,
  output logic [`PFCP_DATA_W-1:0]         flash_data_out,
  output logic                            flash_data_oe_out,
  output logic                            flash_ce_n_out,
  output logic                            flash_oe_n_out,
  output logic                            flash_we_n_out
);
  import pfcp_pkg::*;

  function automatic logic [`PFCP_ADDR_W+`PFCP_DATA_W-1:0] seq_word(
    input pfcp_op_t                op,
    input logic [2:0]              step,
    input logic [`PFCP_ADDR_W-1:0] addr,
    input logic [`PFCP_DATA_W-1:0] data);
    logic [`PFCP_ADDR_W-1:0] u1;
    logic [`PFCP_ADDR_W-1:0] u2;
    logic [`PFCP_DATA_W-1:0] last;
    u1   = `PFCP_ADDR_W'(`PFCP_A_UNLOCK1);
    u2   = `PFCP_ADDR_W'(`PFCP_A_UNLOCK2);
    last = (op == PFCP_OP_CHIP) ? `PFCP_D_CHIP_ERASE : `PFCP_D_BOOT_LOCK;
    if (op == PFCP_OP_RESET)
      return {addr, `PFCP_D_RESET};
    unique case (step)
      3'h0, 3'h3: return (step == `PFCP_STEP_PROG && op == PFCP_OP_PROG) ? {addr, data}
                         : {u1, `PFCP_D_UNLOCK1};                     // [RL21] [RL16]
      3'h1, 3'h4: return {u2, `PFCP_D_UNLOCK2};                        // [RL21]
      3'h2:       return {u1, (op == PFCP_OP_PROG) ? `PFCP_D_PROG_SET : `PFCP_D_ERASE_SET};
      3'h5:       return (op == PFCP_OP_SECT) ? {addr, `PFCP_D_SECT_ERASE}   // [RL12]
                         : {u1, last};                                 // [RL8] [RL10]
      default:    return {u1, `PFCP_D_RESET};
    endcase
  endfunction

  function automatic logic [2:0] last_step(input pfcp_op_t op);
    unique case (op)
      PFCP_OP_PROG:  return `PFCP_STEP_PROG;                           // [RL16]
      PFCP_OP_RESET: return `PFCP_STEP_FIRST;
      default:       return `PFCP_STEP_LAST;                           // [RL8] [RL12]
    endcase
  endfunction

  logic                    rst_meta_q;
  logic                    rst_n_q;
  pfcp_state_t             state_q;
  pfcp_op_t                op_q;
  logic [`PFCP_ADDR_W-1:0] addr_q;
  logic [`PFCP_DATA_W-1:0] data_q;
  logic [2:0]              step_q;
  logic                    has_prev_q;
  logic [`PFCP_DATA_W-1:0] prev_q;
  logic [29:0]             timer_q;
  logic [29:0]             limit;
  logic                    bus_start;
  logic                    bus_done;
  logic [`PFCP_DATA_W-1:0] bus_rdata;
  logic [`PFCP_ADDR_W+`PFCP_DATA_W-1:0] word;
  logic                    accept;
  logic                    refuse;
  logic                    toggled;

  // release reset through two flops; pins idle deselected meanwhile [RL3]
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  assign cmd_ready_out = (state_q == PFCP_ST_IDLE);   // [RL11] [RL19]
  assign rsp_valid_out = (state_q == PFCP_ST_FIN);
  assign accept        = cmd_valid_in && cmd_ready_out;
  assign refuse        = boot_locked_out && (cmd_op_in == PFCP_OP_PROG || cmd_op_in == PFCP_OP_SECT)
                         && cmd_addr_in <= `PFCP_BOOT_TOP;             // [RL18] [RL24]
  assign bus_start     = (state_q == PFCP_ST_WR) || (state_q == PFCP_ST_POLL) || (state_q == PFCP_ST_RD);
  assign word          = seq_word(op_q, step_q, addr_q, data_q);
  assign limit         = (op_q == PFCP_OP_PROG) ? 30'(`PFCP_BP_CYC) : 30'(ERASE_CYCLES); // [RL9] [RL17]
  assign toggled       = bus_rdata[`PFCP_BIT_TOGGLE] != prev_q[`PFCP_BIT_TOGGLE];        // [RL23]

  pfcp_bus_cycle u_bus
  (
    .clk_in            (clk_sys_in),
    .rst_n_in          (rst_n_q),
    .start_in          (bus_start),
    .write_in          (state_q == PFCP_ST_WR),
    .addr_in           ((state_q == PFCP_ST_WR) ? word[`PFCP_ADDR_W+`PFCP_DATA_W-1:`PFCP_DATA_W] : addr_q),
    .wdata_in          (word[`PFCP_DATA_W-1:0]),
    .done_out          (bus_done),
    .rdata_out         (bus_rdata),
    .flash_data_in     (flash_data_in),
    .flash_addr_out    (flash_addr_out),
    .flash_data_out    (flash_data_out),
    .flash_data_oe_out (flash_data_oe_out),
    .flash_ce_n_out    (flash_ce_n_out),
    .flash_oe_n_out    (flash_oe_n_out),
    .flash_we_n_out    (flash_we_n_out)
  );

  // command sequencer; a started sequence always runs to its end [RL25]
  always_ff @(posedge clk_sys_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= PFCP_ST_IDLE;
      op_q    <= PFCP_OP_READ;
      addr_q  <= '0;
      data_q  <= '0;
      step_q  <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        PFCP_ST_IDLE:
          if (accept)
          begin
            op_q   <= cmd_op_in;
            addr_q <= cmd_addr_in;
            data_q <= cmd_data_in;
            step_q <= `PFCP_STEP_FIRST;
            if (refuse)
              state_q <= PFCP_ST_FIN;
            else if (cmd_op_in == PFCP_OP_READ)
              state_q <= PFCP_ST_RD;
            else
              state_q <= PFCP_ST_WR;
          end
        PFCP_ST_WR:
          state_q <= PFCP_ST_WRW;
        PFCP_ST_WRW:
          if (bus_done)
          begin
            if (step_q != last_step(op_q))
            begin
              step_q  <= step_q + 3'h1;
              state_q <= PFCP_ST_WR;
            end
            else if (op_q == PFCP_OP_RESET)
              state_q <= PFCP_ST_FIN;
            else
              state_q <= PFCP_ST_POLL;                        // [RL13] [RL19]
          end
        PFCP_ST_POLL:
          state_q <= PFCP_ST_POLLW;
        PFCP_ST_POLLW:
          if (bus_done)
            state_q <= ((has_prev_q && !toggled) || timer_q >= limit) ? PFCP_ST_FIN : PFCP_ST_POLL;
        PFCP_ST_RD:
          state_q <= PFCP_ST_RDW;
        PFCP_ST_RDW:
          if (bus_done)
            state_q <= PFCP_ST_FIN;
        PFCP_ST_FIN:
          state_q <= PFCP_ST_IDLE;
      endcase
    end
  end

  // toggle tracking and busy timeout
  always_ff @(posedge clk_sys_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      has_prev_q <= 1'b0;
      prev_q     <= '0;
      timer_q    <= '0;
    end
    else if (state_q == PFCP_ST_WR)
    begin
      has_prev_q <= 1'b0;
      timer_q    <= '0;
    end
    else if (state_q == PFCP_ST_POLL || state_q == PFCP_ST_POLLW)
    begin
      timer_q <= timer_q + 30'h1;
      if (bus_done)
      begin
        has_prev_q <= 1'b1;
        prev_q     <= bus_rdata;
      end
    end
  end

  // response data and error
  always_ff @(posedge clk_sys_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rsp_data_out <= '0;
      rsp_err_out  <= 1'b0;
    end
    else if (state_q == PFCP_ST_IDLE && accept)
    begin
      rsp_data_out <= '0;
      rsp_err_out  <= refuse;                                  // [RL18]
    end
    else if (state_q == PFCP_ST_RDW && bus_done)
      rsp_data_out <= bus_rdata;                               // [RL1]
    else if (state_q == PFCP_ST_POLLW && bus_done)
    begin
      rsp_data_out <= bus_rdata;                               // [RL22]
      if (has_prev_q && !toggled)
        rsp_err_out <= (op_q == PFCP_OP_PROG) && (bus_rdata != data_q);  // [RL15] [RL7]
      else if (timer_q >= limit)
        rsp_err_out <= 1'b1;                                   // [RL9] [RL17]
    end
  end

  // lock is permanent in the device, so the shadow only ever sets outside reset; reset clears it
  always_ff @(posedge clk_sys_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      boot_locked_out <= 1'b0;
    else if (state_q == PFCP_ST_POLLW && bus_done && op_q == PFCP_OP_LOCK && has_prev_q && !toggled)
      boot_locked_out <= 1'b1;                                 // [RL18]
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_q);

  a_unlock_first: assert property ($fell(flash_we_n_out) && step_q == `PFCP_STEP_FIRST // [RL21]
    && op_q != PFCP_OP_RESET
    |-> flash_addr_out == `PFCP_ADDR_W'(`PFCP_A_UNLOCK1) && flash_data_out == `PFCP_D_UNLOCK1)
    else $error("first command write is not the unlock");
  a_busy_no_cmd: assert property ((state_q == PFCP_ST_POLL || state_q == PFCP_ST_POLLW) |-> flash_we_n_out) // [RL11]
    else $error("write strobe issued while the device is busy");
  a_boot_refused: assert property (accept && refuse |=> rsp_valid_out && rsp_err_out && flash_ce_n_out) // [RL18]
    else $error("boot block access not refused");
  a_poll_after_seq: assert property ((state_q == PFCP_ST_WRW && bus_done && step_q == 3'h5) // [RL13]
    |=> state_q == PFCP_ST_POLL ##1 !flash_oe_n_out)
    else $error("no polling read after erase sequence");
  a_prog_four: assert property ((op_q == PFCP_OP_PROG) |-> step_q <= 3'h3) // [RL16]
    else $error("program sequence longer than four writes");
  a_sect_sixth: assert property ($fell(flash_we_n_out) && op_q == PFCP_OP_SECT && step_q == `PFCP_STEP_LAST // [RL12]
    |-> flash_data_out == `PFCP_D_SECT_ERASE && flash_addr_out == addr_q)
    else $error("sector erase sixth write wrong");

  c_program:  cover property (state_q == PFCP_ST_FIN && op_q == PFCP_OP_PROG && !rsp_err_out);
  c_chip:     cover property (state_q == PFCP_ST_POLL && op_q == PFCP_OP_CHIP);
  c_read:     cover property (state_q == PFCP_ST_FIN && op_q == PFCP_OP_READ);
  c_refused:  cover property (accept && refuse);
endmodule

// [core/pfcp_regs.svh]
// constants for the parallel flash command port host controller
// assumes a 100 MHz system clock and a byte-wide flash behind the pins
`ifndef PFCP_REGS_SVH
`define PFCP_REGS_SVH

`define PFCP_ADDR_W       19
`define PFCP_DATA_W       8
`define PFCP_CMD_ADDR_W   12

// command table addresses and codes
`define PFCP_A_UNLOCK1    12'h555
`define PFCP_A_UNLOCK2    12'hAAA
`define PFCP_D_UNLOCK1    8'hAA
`define PFCP_D_UNLOCK2    8'h55
`define PFCP_D_ERASE_SET  8'h80
`define PFCP_D_PROG_SET   8'hA0
`define PFCP_D_CHIP_ERASE 8'h10
`define PFCP_D_SECT_ERASE 8'h30
`define PFCP_D_BOOT_LOCK  8'h40
`define PFCP_D_RESET      8'hF0
`define PFCP_STEP_FIRST   3'h0
`define PFCP_STEP_PROG    3'h3
`define PFCP_STEP_LAST    3'h5

// array layout
`define PFCP_BOOT_TOP     19'h03FFF
`define PFCP_BIT_TOGGLE   6

// timing, in printed units, with derived cycle counts
`define PFCP_CLK_NS       10
`define PFCP_T_ACC_NS     55
`define PFCP_T_WP_NS      50
`define PFCP_T_BP_NS      20000
`define PFCP_T_EC_MS      6000
`define PFCP_ACC_CYC      ((`PFCP_T_ACC_NS + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS)
`define PFCP_WP_CYC       ((`PFCP_T_WP_NS + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS)
`define PFCP_BP_CYC       (`PFCP_T_BP_NS / `PFCP_CLK_NS)
`define PFCP_EC_CYC       (`PFCP_T_EC_MS * (1000000 / `PFCP_CLK_NS))

`endif

// [core/pfcp_pkg.sv]
// types for the parallel flash command port host controller
// assumes pfcp_regs.svh holds every number
package pfcp_pkg;

  typedef enum logic [2:0]
  {
    PFCP_OP_READ  = 3'h0,
    PFCP_OP_PROG  = 3'h1,
    PFCP_OP_CHIP  = 3'h2,
    PFCP_OP_SECT  = 3'h3,
    PFCP_OP_LOCK  = 3'h4,
    PFCP_OP_RESET = 3'h5
  } pfcp_op_t;

  typedef enum logic [3:0]
  {
    PFCP_BUS_IDLE   = 4'h1,
    PFCP_BUS_SETUP  = 4'h2,
    PFCP_BUS_STROBE = 4'h4,
    PFCP_BUS_HOLD   = 4'h8
  } pfcp_bus_state_t;

  typedef enum logic [7:0]
  {
    PFCP_ST_IDLE  = 8'h01,
    PFCP_ST_WR    = 8'h02,
    PFCP_ST_WRW   = 8'h04,
    PFCP_ST_POLL  = 8'h08,
    PFCP_ST_POLLW = 8'h10,
    PFCP_ST_RD    = 8'h20,
    PFCP_ST_RDW   = 8'h40,
    PFCP_ST_FIN   = 8'h80
  } pfcp_state_t;

endpackage

// [core/pfcp_bus_cycle.sv]
// one read or write cycle on the flash pins
// assumes the caller holds start only while this engine is idle
`timescale 1ns/1ps
`include "pfcp_regs.svh"

module pfcp_bus_cycle
(
  // clock and synchronised reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // request
  input  wire logic                      start_in,
  input  wire logic                      write_in,
  input  wire logic [`PFCP_ADDR_W-1:0]   addr_in,
  input  wire logic [`PFCP_DATA_W-1:0]   wdata_in,
  output logic                           done_out,
  output logic [`PFCP_DATA_W-1:0]        rdata_out,
  // flash pins
  input  wire logic [`PFCP_DATA_W-1:0]   flash_data_in,
  output logic [`PFCP_ADDR_W-1:0]        flash_addr_out,
  output logic [`PFCP_DATA_W-1:0]        flash_data_out,
  output logic                           flash_data_oe_out,
  output logic                           flash_ce_n_out,
  output logic                           flash_oe_n_out,
  output logic                           flash_we_n_out
);
  import pfcp_pkg::*;

  pfcp_bus_state_t state_q;
  logic [3:0]      cnt_q;
  logic            write_q;

  assign done_out = (state_q == PFCP_BUS_HOLD);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= PFCP_BUS_IDLE;
      cnt_q   <= 4'h0;
      write_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        PFCP_BUS_IDLE:
        begin
          cnt_q <= 4'h0;
          if (start_in)
          begin
            state_q <= PFCP_BUS_SETUP;
            write_q <= write_in;
          end
        end
        PFCP_BUS_SETUP:
        begin
          if (write_q)
            state_q <= PFCP_BUS_STROBE;
          else if (cnt_q == 4'(`PFCP_ACC_CYC - 1))
            state_q <= PFCP_BUS_HOLD;
          else
            cnt_q <= cnt_q + 4'h1;
        end
        PFCP_BUS_STROBE:
        begin
          if (cnt_q == 4'(`PFCP_WP_CYC - 1))
            state_q <= PFCP_BUS_HOLD;
          else
            cnt_q <= cnt_q + 4'h1;
        end
        PFCP_BUS_HOLD:
          state_q <= PFCP_BUS_IDLE;
      endcase
    end
  end

  // address set before the strobe falls, data held past its rise [RL5]
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flash_addr_out    <= '0;
      flash_data_out    <= '0;
      flash_data_oe_out <= 1'b0;
      flash_ce_n_out    <= 1'b1;
      flash_oe_n_out    <= 1'b1;
      flash_we_n_out    <= 1'b1;
    end
    else if (state_q == PFCP_BUS_IDLE && start_in)
    begin
      flash_addr_out    <= addr_in;
      flash_data_out    <= wdata_in;
      flash_data_oe_out <= write_in;   // [RL2]
      flash_ce_n_out    <= 1'b0;
      flash_oe_n_out    <= write_in;   // [RL1] [RL4]
    end
    else if (state_q == PFCP_BUS_SETUP && write_q)
      flash_we_n_out <= 1'b0;          // [RL4]
    else if (state_q == PFCP_BUS_STROBE && cnt_q == 4'(`PFCP_WP_CYC - 1))
      flash_we_n_out <= 1'b1;
    else if (state_q == PFCP_BUS_HOLD)
    begin
      flash_ce_n_out    <= 1'b1;
      flash_oe_n_out    <= 1'b1;
      flash_data_oe_out <= 1'b0;
    end
  end

  // sample at the end of the access time [RL1]
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= '0;
    else if (state_q == PFCP_BUS_SETUP && !write_q && cnt_q == 4'(`PFCP_ACC_CYC - 1))
      rdata_out <= flash_data_in;
  end

  a_strobe_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    (!flash_we_n_out && $past(!flash_we_n_out)) |-> ($stable(flash_addr_out) && $stable(flash_data_out)))
    else $error("address or data moved under the write strobe");
  a_write_oe_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    !flash_we_n_out |-> (flash_oe_n_out && !flash_ce_n_out && flash_data_oe_out))
    else $error("write strobe low without chip select or with output enable");
  a_no_contention: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL2]
    !flash_oe_n_out |-> (!flash_data_oe_out && flash_we_n_out))
    else $error("host drives data while output enable is low");
  a_strobe_width: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    $fell(flash_we_n_out) |-> !flash_we_n_out [*5] ##1 flash_we_n_out)
    else $error("write strobe width wrong");
endmodule

// [verification/pfcp_flash_model.sv]
// behavioural byte-wide flash: unlock decoder, sectors, lockout, toggle status
// assumes the host pulses we_n inside a ce_n low window with oe_n high
`timescale 1ns/1ps

module pfcp_flash_model
#(
  parameter int PROG_NS  = 3000,
  parameter int ERASE_NS = 1000
)
(
  // pins
  input  wire logic [18:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe_out
);
  logic [7:0]  mem_q [int];
  logic [18:0] lat_a;
  logic [7:0]  last_d;
  logic [2:0]  step;
  logic        erase_mode;
  logic        locked;
  logic        busy;
  logic        tog;
  int          dly;
  event        go;

  // erased bits read as one
  function automatic logic [7:0] rd(int a);
    return mem_q.exists(a) ? mem_q[a] : 8'hFF;
  endfunction

  function automatic int sid(int a);
    return a < 19'h04000 ? 0 : a < 19'h06000 ? 1 : a < 19'h08000 ? 2 : a < 19'h10000 ? 3 : (a >> 16) + 3;
  endfunction

  assign dq_oe_out = !ce_n_in && !oe_n_in && we_n_in;
  assign dq_out = busy ? {~last_d[7], tog, last_d[5:0]} : rd(addr_in);

  initial
  begin
    step = 3'h0; // powers up in read mode
    erase_mode = 1'b0;
    locked = 1'b0;
    busy = 1'b0;
    tog = 1'b0;
    last_d = 8'hFF;
  end

  always
  begin
    @(go);
    busy = 1'b1;
    #(dly);
    busy = 1'b0; // self timed, no clock
  end

  // select and output enable fall in the same step; look once both settled
  always @(negedge oe_n_in)
  begin
    #1;
    if (!ce_n_in && busy)
      tog = ~tog;
  end

  always @(negedge we_n_in)
    if (!ce_n_in)
      lat_a = addr_in;

  // sixth sector erase cycle takes its address on the rising strobe
  always @(posedge we_n_in)
    if (!ce_n_in && oe_n_in && !busy)
      take(step == 3'h5 ? addr_in : lat_a, dq_in);

  task automatic wipe(logic all, int a);
    int q[$];
    foreach (mem_q[k])
      if ((all || sid(k) == sid(a)) && !(locked && sid(k) == 0))
        q.push_back(k);
    foreach (q[i])
      mem_q.delete(q[i]);
    last_d = 8'hFF;
    dly = ERASE_NS;
    -> go;
  endtask

  task automatic burn(int a, logic [7:0] d);
    if (!(locked && sid(a) == 0))
      mem_q[a] = rd(a) & d; // only clears bits
    last_d = d;
    dly = PROG_NS;
    -> go;
  endtask

  // command cycles never touch the array
  task automatic take(logic [18:0] a, logic [7:0] d);
    logic u1;
    logic u2;
    u1 = a[11:0] == 12'h555;
    u2 = a[11:0] == 12'hAAA;
    case (step)
      3'h0: step = (u1 && d == 8'hAA) ? 3'h1 : 3'h0;
      3'h1: step = (u2 && d == 8'h55) ? 3'h2 : 3'h0;
      3'h2:
      begin
        erase_mode = d == 8'h80;
        step = (u1 && (erase_mode || d == 8'hA0)) ? 3'h3 : 3'h0;
      end
      3'h3:
      begin
        step = (erase_mode && u1 && d == 8'hAA) ? 3'h4 : 3'h0;
        if (!erase_mode)
          burn(a, d);
      end
      3'h4: step = (u2 && d == 8'h55) ? 3'h5 : 3'h0;
      default:
      begin
        step = 3'h0; // broken sequences drop back to read
        if (d == 8'h30)
          wipe(1'b0, a);
        else if (u1 && d == 8'h10)
          wipe(1'b1, a);
        else if (u1 && d == 8'h40)
          locked = 1'b1;
      end
    endcase
  endtask
endmodule

// [verification/pfcp_ctrl_tb_top.sv]
// bench for the flash command port host controller against the flash model
// assumes model busy times below the controller's poll bounds
`timescale 1ns/1ps

module pfcp_ctrl_tb_top;
  import pfcp_pkg::*;

  logic        clk_sys_in, arst_n_in, cmd_valid_in, cmd_ready_out, rsp_valid_out, rsp_err_out;
  pfcp_op_t    cmd_op_in;
  logic [18:0] cmd_addr_in, flash_addr_out;
  logic [7:0]  cmd_data_in, rsp_data_out, flash_data_out, dev_d, bus, bus_q;
  logic        boot_locked_out, flash_data_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, dev_oe;
  int          errors, checks_done, wr_cnt;

  // released bus shows a changing pattern, never the last value
  assign bus = flash_data_oe_out ? flash_data_out : dev_oe ? dev_d : ~bus_q;
  always @(posedge clk_sys_in)
    bus_q <= bus;

  always @(posedge flash_we_n_out)
    if (!flash_ce_n_out && flash_oe_n_out)
      wr_cnt++;

  pfcp_ctrl #(.ERASE_CYCLES(200)) DUT
  (
    .clk_sys_in, .arst_n_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in, .cmd_data_in, .cmd_ready_out,
    .rsp_valid_out, .rsp_data_out, .rsp_err_out, .boot_locked_out, .flash_data_in(bus), .flash_addr_out,
    .flash_data_out, .flash_data_oe_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out
  );

  pfcp_flash_model FLASH
  (
    .addr_in(flash_addr_out), .dq_in(bus), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .dq_out(dev_d), .dq_oe_out(dev_oe)
  );

  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(string what, logic [18:0] seen, logic [18:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // entered just after an edge; holds valid until the taking edge
  task automatic cmd(pfcp_op_t op, logic [18:0] a, logic [7:0] d);
    int n;
    wr_cnt = 0;
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_data_in = d;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    @(posedge clk_sys_in);
    #1;
    cmd_valid_in = 1'b0;
    chk("ready while busy", cmd_ready_out, 1'b0);
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    chk("response", n < 3000, 1);
  endtask

  task automatic t_prog();
    chk("idle pins", {flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_data_oe_out}, 4'hE);
    cmd(PFCP_OP_READ, 19'h12345, 8'h00);
    chk("erased byte", rsp_data_out, 8'hFF);
    cmd(PFCP_OP_PROG, 19'h12345, 8'h5A);
    chk("program cycles", {rsp_err_out, wr_cnt[3:0]}, 5'h04);
    cmd(PFCP_OP_READ, 19'h12345, 8'h00);
    chk("programmed byte", rsp_data_out, 8'h5A);
    cmd(PFCP_OP_PROG, 19'h12345, 8'hA5);
    chk("clear-only mismatch", {rsp_err_out, rsp_data_out}, 9'h100);
    cmd(PFCP_OP_READ, 19'h00555, 8'h00);
    chk("unlock location", rsp_data_out, 8'hFF);
  endtask

  task automatic t_sect();
    cmd(PFCP_OP_PROG, 19'h05FFF, 8'h11);
    cmd(PFCP_OP_PROG, 19'h06000, 8'h22);
    cmd(PFCP_OP_PROG, 19'h7FFFF, 8'h33);
    cmd(PFCP_OP_SECT, 19'h04000, 8'h00);
    chk("sector cycles", wr_cnt, 6);
    cmd(PFCP_OP_READ, 19'h05FFF, 8'h00);
    chk("param 1 erased", rsp_data_out, 8'hFF);
    cmd(PFCP_OP_READ, 19'h06000, 8'h00);
    chk("param 2 kept", rsp_data_out, 8'h22);
    cmd(PFCP_OP_READ, 19'h7FFFF, 8'h00);
    chk("top byte kept", rsp_data_out, 8'h33);
  endtask

  task automatic t_lock();
    cmd(PFCP_OP_PROG, 19'h00100, 8'hA5);
    cmd(PFCP_OP_LOCK, 19'h00000, 8'h00);
    chk("lock cycles", {boot_locked_out, wr_cnt[3:0]}, 5'h16);
    cmd(PFCP_OP_SECT, 19'h03FFF, 8'h00);
    chk("boot erase refused", {rsp_err_out, wr_cnt[3:0]}, 5'h10);
    cmd(PFCP_OP_PROG, 19'h04000, 8'h0F);
    chk("first open byte", rsp_err_out, 1'b0);
    cmd(PFCP_OP_CHIP, 19'h00000, 8'h00);
    chk("chip erase cycles", wr_cnt, 6);
    cmd(PFCP_OP_READ, 19'h04000, 8'h00);
    chk("array erased", rsp_data_out, 8'hFF);
    cmd(PFCP_OP_READ, 19'h00100, 8'h00);
    chk("boot kept", rsp_data_out, 8'hA5);
    cmd(PFCP_OP_RESET, 19'h00000, 8'h00);
    chk("reset cycle", wr_cnt, 1);
  endtask

  // mid-run reset: the shadow clears, the device keeps its lock and data
  task automatic t_reset();
    arst_n_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk("lock shadow cleared", boot_locked_out, 1'b0);
    chk("pins idle in reset", {flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_data_oe_out}, 4'hE);
    arst_n_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    cmd(PFCP_OP_READ, 19'h00100, 8'h00);
    chk("boot kept after reset", rsp_data_out, 8'hA5);
  endtask

  initial
  begin
    #500000;
    errors++;
    finish_test();
  end

  initial
  begin
    errors = 0;
    checks_done = 0;
    wr_cnt = 0;
    bus_q = 8'h00;
    arst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_op_in = PFCP_OP_READ;
    cmd_addr_in = 19'h00000;
    cmd_data_in = 8'h00;
    repeat (16) @(posedge clk_sys_in);
    #1;
    arst_n_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    t_prog();
    t_sect();
    t_lock();
    t_reset();
    finish_test();
  end
endmodule
